// ### rtl/alert_pkg.sv
// Constants for the command parity and write CRC alert reporter
package alert_pkg;
	// Speed grade codes
	localparam logic [1:0] GRADE_2400 = 2'h0;
	localparam logic [1:0] GRADE_2666 = 2'h1;
	localparam logic [1:0] GRADE_2933 = 2'h2;
	localparam logic [1:0] GRADE_3200 = 2'h3;
	// Parity latency in link clocks
	localparam logic [7:0] PL_SLOW = 8'h05;
	localparam logic [7:0] PL_FAST = 8'h06;
	// Parity alert pulse width, least and most, in link clocks
	localparam logic [7:0] PAR_PW_MIN_2400 = 8'h48;
	localparam logic [7:0] PAR_PW_MIN_2666 = 8'h50;
	localparam logic [7:0] PAR_PW_MIN_2933 = 8'h58;
	localparam logic [7:0] PAR_PW_MIN_3200 = 8'h60;
	localparam logic [7:0] PAR_PW_MAX_2400 = 8'h90;
	localparam logic [7:0] PAR_PW_MAX_2666 = 8'hA0;
	localparam logic [7:0] PAR_PW_MAX_2933 = 8'hB0;
	localparam logic [7:0] PAR_PW_MAX_3200 = 8'hC0;
	// Controller response window in persistent mode, link clocks
	localparam logic [7:0] RSP_2400 = 8'h40;
	localparam logic [7:0] RSP_2666 = 8'h47;
	localparam logic [7:0] RSP_2933 = 8'h4E;
	localparam logic [7:0] RSP_3200 = 8'h55;
	// CRC alert pulse width in link clocks
	localparam logic [7:0] CRC_PW_MIN = 8'h06;
	localparam logic [7:0] CRC_PW_MAX = 8'h0A;
	// System clock period and alert latency times in ns
	localparam int CLK_PERIOD_NS = 8;
	localparam int PAR_EXTRA_NS  = 6;
	localparam int CRC_ON_MIN_NS = 3;
	localparam int CRC_ON_MAX_NS = 13;
	// Least time rounds up, longest rounds down, never below one cycle
	localparam int CRC_ON_MIN_CYC_RAW = (CRC_ON_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CRC_ON_MAX_CYC_RAW = CRC_ON_MAX_NS / CLK_PERIOD_NS;
	localparam int PAR_EXTRA_CYC_RAW  = PAR_EXTRA_NS / CLK_PERIOD_NS;
	localparam int CRC_ON_MIN_CYC = (CRC_ON_MIN_CYC_RAW < 1) ? 1 : CRC_ON_MIN_CYC_RAW;
	localparam int CRC_ON_MAX_CYC = (CRC_ON_MAX_CYC_RAW < 1) ? 1 : CRC_ON_MAX_CYC_RAW;
	localparam int PAR_EXTRA_CYC  = (PAR_EXTRA_CYC_RAW < 1) ? 1 : PAR_EXTRA_CYC_RAW;
	// Delay from CRC error to alert, system cycles
	localparam logic [3:0] CRC_ON_DELAY = 4'(CRC_ON_MIN_CYC);
	// Reset values
	localparam logic [7:0] CNT_RESET = 8'h00;
endpackage

// ### rtl/link_evt_if.sv
// Carrier for sampled link events between the sampler and the reporter
`timescale 1ns/100ps
interface link_evt_if;
	logic ck_rise;  // One-cycle pulse per link clock rising edge
	logic par_err;  // Parity fail seen at a link edge
	logic crc_err;  // Rising edge of the CRC fail level
	logic des_seen; // Deselect seen at a link edge
	modport src (output ck_rise, output par_err, output crc_err, output des_seen);
	modport dst (input ck_rise, input par_err, input crc_err, input des_seen);
endinterface

// ### rtl/link_sampler.sv
// Synchronises the link pins and turns them into one-cycle events
`timescale 1ns/100ps
module link_sampler (
	input  wire logic clock,
	input  wire logic sys_rst,
	input  wire logic link_ck,
	input  wire logic par_fail,
	input  wire logic crc_fail,
	input  wire logic deselect,
	link_evt_if.src   ev
);
	logic [3:0] meta;
	logic [3:0] sync;
	logic [3:0] next_meta;
	logic [3:0] next_sync;
	logic       ck_prev;
	logic       crc_prev;
	logic       next_ck_prev;
	logic       next_crc_prev;

	// Two flops on every pin; only the second stage feeds logic
	always_comb begin
		next_meta     = {deselect, crc_fail, par_fail, link_ck};
		next_sync     = meta;
		next_ck_prev  = sync[0];
		next_crc_prev = sync[2];
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			meta     <= 4'h0;
			sync     <= 4'h0;
			ck_prev  <= 1'b0;
			crc_prev <= 1'b0;
		end else begin
			meta     <= next_meta;
			sync     <= next_sync;
			ck_prev  <= next_ck_prev;
			crc_prev <= next_crc_prev;
		end
	end

	// Parity and deselect are qualified by the link edge, like a real command
	assign ev.ck_rise  = sync[0] & ~ck_prev;
	assign ev.par_err  = sync[0] & ~ck_prev & sync[1];
	assign ev.crc_err  = sync[2] & ~crc_prev;
	assign ev.des_seen = sync[0] & ~ck_prev & sync[3];
endmodule // link_sampler

// ### rtl/alert_reporter.sv
// Alert reporter for command parity and write CRC errors
`timescale 1ns/100ps
module alert_reporter
	import alert_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       sys_rst,
	input  wire logic       link_ck,
	input  wire logic       par_fail,
	input  wire logic       crc_fail,
	input  wire logic       deselect,
	input  wire logic [1:0] speed_grade,
	input  wire logic       persistent_mode,
	input  wire logic       late_clear,
	output logic            alert_n_out,
	output logic            alert_n_oe,
	output logic            cmd_block,
	output logic            par_active,
	output logic            crc_active,
	output logic            rsp_late
);
	typedef enum logic [3:0] {
		ST_IDLE      = 4'b0001,
		ST_CRC_WAIT  = 4'b0010,
		ST_CRC_PULSE = 4'b0100,
		ST_PAR_PULSE = 4'b1000
	} alert_state_t;

	link_evt_if ev ();

	link_sampler u_sampler (
		.clock    (clock),
		.sys_rst  (sys_rst),
		.link_ck  (link_ck),
		.par_fail (par_fail),
		.crc_fail (crc_fail),
		.deselect (deselect),
		.ev       (ev.src)
	);

	// Parity latency for the grade
	function automatic logic [7:0] parity_latency(input logic [1:0] g);
		parity_latency = (g == GRADE_2400 || g == GRADE_2666) ? PL_SLOW : PL_FAST;
	endfunction

	// Parity alert pulse length; the least width keeps the error report fastest
	function automatic logic [7:0] par_width(input logic [1:0] g);
		unique case (g)
			GRADE_2400: par_width = PAR_PW_MIN_2400;
			GRADE_2666: par_width = PAR_PW_MIN_2666;
			GRADE_2933: par_width = PAR_PW_MIN_2933;
			GRADE_3200: par_width = PAR_PW_MIN_3200;
		endcase
	endfunction

	// Controller response window for the grade
	function automatic logic [7:0] rsp_window(input logic [1:0] g);
		unique case (g)
			GRADE_2400: rsp_window = RSP_2400;
			GRADE_2666: rsp_window = RSP_2666;
			GRADE_2933: rsp_window = RSP_2933;
			GRADE_3200: rsp_window = RSP_3200;
		endcase
	endfunction

	alert_state_t state;
	alert_state_t next_state;
	logic [1:0]   grade;
	logic [1:0]   next_grade;
	logic [7:0]   pulse_cnt;
	logic [7:0]   next_pulse_cnt;
	logic [3:0]   wait_cnt;
	logic [3:0]   next_wait_cnt;
	logic [7:0]   blk_cnt;
	logic [7:0]   next_blk_cnt;
	logic [7:0]   rsp_cnt;
	logic [7:0]   next_rsp_cnt;
	logic         rsp_armed;
	logic         next_rsp_armed;
	logic         next_alert_n;
	logic         next_cmd_block;
	logic         next_rsp_late;
	logic         next_alert_oe;
	logic         next_par_active;
	logic         next_crc_active;

	// Alert sequencer; a parity error outranks a CRC report in any state
	always_comb begin
		next_state     = state;
		next_pulse_cnt = pulse_cnt;
		next_wait_cnt  = wait_cnt;
		// Grade is frozen while a pulse runs so its width cannot shift midway
		next_grade     = (state == ST_IDLE) ? speed_grade : grade;
		unique case (state)
			ST_IDLE: begin
				if (ev.par_err) begin
					next_state     = ST_PAR_PULSE;
					next_pulse_cnt = CNT_RESET;
				end else if (ev.crc_err) begin
					next_state    = ST_CRC_WAIT;
					next_wait_cnt = CRC_ON_DELAY - 4'h1;
				end
			end
			ST_CRC_WAIT: begin
				if (ev.par_err) begin
					next_state     = ST_PAR_PULSE;
					next_pulse_cnt = CNT_RESET;
				end else if (wait_cnt == 4'h0) begin
					next_state     = ST_CRC_PULSE;
					next_pulse_cnt = CNT_RESET;
				end else begin
					next_wait_cnt = wait_cnt - 4'h1;
				end
			end
			ST_CRC_PULSE: begin
				// A second CRC error inside the pulse is merged into it
				if (ev.par_err) begin
					next_state     = ST_PAR_PULSE;
					next_pulse_cnt = CNT_RESET;
				end else if (ev.ck_rise) begin
					// One edge past the least width: the first edge may land just after the start
					if (pulse_cnt == CRC_PW_MIN) begin
						next_state = ST_IDLE;
					end
					next_pulse_cnt = pulse_cnt + 8'h01;
				end
			end
			ST_PAR_PULSE: begin
				// Further errors during a parity pulse are not reported again
				if (ev.ck_rise) begin
					// One edge spare so edge quantisation never leaves the pulse short
					if (pulse_cnt == par_width(grade)) begin
						next_state = ST_IDLE;
					end
					next_pulse_cnt = pulse_cnt + 8'h01;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		// Open-drain style: low only while a pulse is on the pin
		next_alert_n = ~(next_state == ST_CRC_PULSE || next_state == ST_PAR_PULSE);
		next_alert_oe   = ~next_alert_n;
		next_par_active = (next_state == ST_PAR_PULSE);
		next_crc_active = (next_state == ST_CRC_PULSE);
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state       <= ST_IDLE;
			grade       <= GRADE_2400;
			pulse_cnt   <= CNT_RESET;
			wait_cnt    <= 4'h0;
			alert_n_out <= 1'b1;
			alert_n_oe  <= 1'b0;
			par_active  <= 1'b0;
			crc_active  <= 1'b0;
		end else begin
			state       <= next_state;
			grade       <= next_grade;
			pulse_cnt   <= next_pulse_cnt;
			wait_cnt    <= next_wait_cnt;
			alert_n_out <= next_alert_n;
			alert_n_oe  <= next_alert_oe;
			par_active  <= next_par_active;
			crc_active  <= next_crc_active;
		end
	end

	// Command inhibit window counted in link edges after the errant command
	always_comb begin
		next_blk_cnt = blk_cnt;
		if (ev.par_err && state != ST_PAR_PULSE) begin
			next_blk_cnt = parity_latency(speed_grade);
		end else if (ev.ck_rise && blk_cnt != CNT_RESET) begin
			next_blk_cnt = blk_cnt - 8'h01;
		end
		next_cmd_block = (next_blk_cnt != CNT_RESET);
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			blk_cnt   <= CNT_RESET;
			cmd_block <= 1'b0;
		end else begin
			blk_cnt   <= next_blk_cnt;
			cmd_block <= next_cmd_block;
		end
	end

	// Persistent mode watchdog on the controller's deselect response
	always_comb begin
		next_rsp_cnt   = rsp_cnt;
		next_rsp_armed = rsp_armed;
		next_rsp_late  = rsp_late;
		if (late_clear) begin
			next_rsp_late = 1'b0;
		end
		if (ev.par_err && state != ST_PAR_PULSE && persistent_mode) begin
			next_rsp_armed = 1'b1;
			next_rsp_cnt   = CNT_RESET;
		end else if (rsp_armed && ev.des_seen) begin
			next_rsp_armed = 1'b0;
		end else if (rsp_armed && ev.ck_rise) begin
			if (rsp_cnt == rsp_window(grade) - 8'h01) begin
				// Set wins over a clear in the same cycle
				next_rsp_late  = 1'b1;
				next_rsp_armed = 1'b0;
			end
			next_rsp_cnt = rsp_cnt + 8'h01;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rsp_cnt   <= CNT_RESET;
			rsp_armed <= 1'b0;
			rsp_late  <= 1'b0;
		end else begin
			rsp_cnt   <= next_rsp_cnt;
			rsp_armed <= next_rsp_armed;
			rsp_late  <= next_rsp_late;
		end
	end
endmodule // alert_reporter

// ### bench/alert_checker_sva.sv
// Port-level timing checker for the alert reporter
`timescale 1ns/100ps
module alert_checker (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic crc_fail,
	input wire logic persistent_mode,
	input wire logic late_clear,
	input wire logic alert_n_out,
	input wire logic alert_n_oe,
	input wire logic cmd_block,
	input wire logic par_active,
	input wire logic crc_active,
	input wire logic rsp_late
);
	logic [11:0] par_cnt, next_par_cnt, crc_cnt, next_crc_cnt;
	// Pulse lengths in system cycles; widths exceed one delay range
	always_comb begin
		next_par_cnt = par_active ? par_cnt + 12'h001 : 12'h000;
		next_crc_cnt = crc_active ? crc_cnt + 12'h001 : 12'h000;
	end
	always_ff @(posedge clock) begin
		par_cnt <= sys_rst ? 12'h000 : next_par_cnt;
		crc_cnt <= sys_rst ? 12'h000 : next_crc_cnt;
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	oe_match_a: assert property (alert_n_oe == !alert_n_out)
		else $error("enable not inverse of pin");
	idle_high_a: assert property (!par_active && !crc_active |-> alert_n_out)
		else $error("pin low without a pulse");
	par_low_a: assert property (par_active |-> !alert_n_out && !crc_active)
		else $error("parity pulse not on pin");
	par_block_a: assert property ($rose(par_active) |-> cmd_block[*8])
		else $error("commands not blocked");
	block_end_a: assert property ($rose(cmd_block) |-> ##[1:120] !cmd_block)
		else $error("block too long");
	par_min_a: assert property ($fell(par_active) |-> par_cnt >= 12'h465)
		else $error("parity pulse too short");
	par_max_a: assert property (par_cnt <= 12'hBCC)
		else $error("parity pulse too long");
	crc_on_a: assert property ($rose(crc_fail) && !crc_active && !par_active |-> ##[1:8] crc_active)
		else $error("crc alert late");
	crc_min_a: assert property ($fell(crc_active) && !par_active |-> crc_cnt >= 12'h05E)
		else $error("crc pulse too short");
	crc_max_a: assert property ($rose(crc_active) |-> ##[1:170] !crc_active)
		else $error("crc pulse too long");
	late_hold_a: assert property (!persistent_mode && !rsp_late |=> !rsp_late)
		else $error("late flag outside persistent mode");
	late_clr_a: assert property (late_clear && !par_active |=> !rsp_late)
		else $error("late flag not cleared");
endmodule // alert_checker
bind alert_reporter alert_checker chk (.clock(clock), .sys_rst(sys_rst), .crc_fail(crc_fail),
	.persistent_mode(persistent_mode), .late_clear(late_clear), .alert_n_out(alert_n_out),
	.alert_n_oe(alert_n_oe), .cmd_block(cmd_block), .par_active(par_active),
	.crc_active(crc_active), .rsp_late(rsp_late));

// ### bench/ctrl_model.sv
// Memory controller model: link clock, fail levels and deselects
`timescale 1ns/100ps
module ctrl_model (
	input  wire logic run,
	input  wire logic par_req,
	input  wire logic crc_req,
	input  wire logic des_en,
	output logic      link_ck,
	output logic      par_fail,
	output logic      crc_fail,
	output logic      deselect
);
	initial begin
		link_ck = 1'b0;
		par_fail = 1'b0;
		deselect = 1'b0;
	end
	// Link clock stands still between frames
	always #62.5 link_ck = run ? ~link_ck : 1'b0;
	// Parity and deselect levels move on the falling edge, clear of the sampling edge; the CRC level follows crc_req at once
	always @(negedge link_ck) begin
		par_fail <= par_req;
		deselect <= des_en;
	end
	assign crc_fail = crc_req;
endmodule // ctrl_model

// ### bench/test_alert_reporter.sv
// Self-checking bench for the alert reporter
`timescale 1ns/100ps
module test_alert_reporter;
	logic       clock = 1'b0, sys_rst = 1'b1, run = 1'b0, par_req = 1'b0, crc_req = 1'b0;
	logic       des_en = 1'b0, persistent_mode = 1'b0, late_clear = 1'b0;
	logic [1:0] speed_grade = 2'h0;
	logic       link_ck, par_fail, crc_fail, deselect, alert_n_out, alert_n_oe;
	logic       cmd_block, par_active, crc_active, rsp_late;
	int         fail_count = 0, checks_done = 0;
	// Grade, parity latency, least and most pulse width in link clocks
	int         rows [4][4] = '{'{0, 5, 72, 144}, '{1, 5, 80, 160}, '{2, 6, 88, 176}, '{3, 6, 96, 192}};
	realtime    t0, ta, tb, tc;
	always #4 clock = ~clock;
	ctrl_model pm (.run(run), .par_req(par_req), .crc_req(crc_req), .des_en(des_en),
		.link_ck(link_ck), .par_fail(par_fail), .crc_fail(crc_fail), .deselect(deselect));
	alert_reporter dut (.clock(clock), .sys_rst(sys_rst), .link_ck(link_ck), .par_fail(par_fail),
		.crc_fail(crc_fail), .deselect(deselect), .speed_grade(speed_grade),
		.persistent_mode(persistent_mode), .late_clear(late_clear), .alert_n_out(alert_n_out),
		.alert_n_oe(alert_n_oe), .cmd_block(cmd_block), .par_active(par_active),
		.crc_active(crc_active), .rsp_late(rsp_late));
	task chk(input logic ok, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("[ERR] %0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// Steps stay 1 ns past the edge so registered outputs have settled
	task wait_pin(input logic v, output realtime t);
		for (int n = 0; n < 4000 && alert_n_out !== v; n++) #8;
		t = $realtime;
		// A pin that never moves counts as a mismatch, not a silent pass
		chk(alert_n_out === v, alert_n_out, v);
	endtask
	// One bad command; t0 is the link edge that carries it
	task par_err;
		@(posedge clock) #1 par_req = 1'b1;
		@(posedge par_fail);
		@(posedge link_ck) t0 = $realtime;
		@(posedge clock) #1 par_req = 1'b0;
		wait_pin(1'b0, ta);
	endtask
	initial begin
		repeat (16) @(posedge clock);
		#1 sys_rst = 1'b0;
		chk({alert_n_out, alert_n_oe, cmd_block, par_active, crc_active, rsp_late} === 6'h20,
			{alert_n_out, alert_n_oe, cmd_block, par_active, crc_active, rsp_late}, 32'h20);
		run = 1'b1;
		$display("reset test done");
		foreach (rows[i]) begin
			speed_grade = 2'(rows[i][0]);
			par_err();
			chk(ta - t0 <= rows[i][1] * 125 + 6, ta - t0, rows[i][1] * 125 + 6);
			while (cmd_block === 1'b1) #8;
			tb = $realtime;
			chk(tb - t0 >= rows[i][1] * 125, tb - t0, rows[i][1] * 125);
			wait_pin(1'b1, tc);
			chk(tc - ta >= rows[i][2] * 125 && tc - ta <= rows[i][3] * 125,
				tc - ta, rows[i][2] * 125);
			$display("grade %0d test done", i);
		end
		// A write CRC error gives the short pulse
		@(posedge clock) #1 crc_req = 1'b1;
		t0 = $realtime;
		wait_pin(1'b0, ta);
		chk(crc_active === 1'b1 && par_active === 1'b0, {crc_active, par_active}, 32'h2);
		chk(ta - t0 <= 48, ta - t0, 48);
		wait_pin(1'b1, tc);
		crc_req = 1'b0;
		chk(tc - ta >= 750 && tc - ta <= 1250, tc - ta, 750);
		$display("crc test done");
		// Persistent mode with a silent controller, then a prompt one
		persistent_mode = 1'b1;
		par_err();
		wait_pin(1'b1, tc);
		chk(rsp_late === 1'b1, rsp_late, 32'h1);
		late_clear = 1'b1;
		#8 late_clear = 1'b0;
		#8 chk(rsp_late === 1'b0, rsp_late, 32'h0);
		des_en = 1'b1;
		par_err();
		#800 crc_req = 1'b1;
		wait_pin(1'b1, tc);
		chk(rsp_late === 1'b0, rsp_late, 32'h0);
		// Give a remembered CRC error time to show, which it must not
		#40 chk(crc_active === 1'b0 && alert_n_out === 1'b1, {crc_active, alert_n_out}, 32'h1);
		crc_req = 1'b0;
		$display("persistent test done");
		// Reset in the middle of a parity pulse leaves nothing behind
		par_err();
		@(posedge clock) #1 sys_rst = 1'b1;
		repeat (16) @(posedge clock);
		#1 sys_rst = 1'b0;
		chk({alert_n_out, alert_n_oe, cmd_block, par_active, crc_active, rsp_late} === 6'h20,
			{alert_n_out, alert_n_oe, cmd_block, par_active, crc_active, rsp_late}, 32'h20);
		#2000 chk(alert_n_out === 1'b1 && cmd_block === 1'b0, {alert_n_out, cmd_block}, 32'h2);
		$display("midrun reset test done");
		stop_test();
	end
	// Longest run is about 70 us of link traffic
	initial begin
		#500000;
		fail_count++;
		stop_test();
	end
endmodule // test_alert_reporter
